/* logic/msd_pkg.sv */
/*
  package for the memory select and page decode block: configuration
  register offsets, space-map field positions, id field layout.
  assumes a 20 MHz core clock and an 8-bit mcu bus sampled on it.
*/
package msd_pkg;

  // ==========================================================
  // config register space offsets
  localparam logic [7:0] MSD_OFS_SPACE_MAP = 8'hc2;
  localparam logic [7:0] MSD_OFS_INFO0 = 8'hf0;
  localparam logic [7:0] MSD_OFS_INFO1 = 8'hf1;
  localparam logic [7:0] MSD_OFS_PAGE = 8'he0;

  // ==========================================================
  // space-map bit positions
  localparam int MSD_SM_SRAM_CODE = 0;
  localparam int MSD_SM_BOOT_CODE = 1;
  localparam int MSD_SM_MAIN_FLASH_CODE_EN = 2;
  localparam int MSD_SM_BOOT_DATA = 3;
  localparam int MSD_SM_MAIN_FLASH_DATA_EN = 4;
  localparam int MSD_SM_PIO = 7;
  localparam logic [7:0] MSD_SM_USED_MASK = 8'h9f;

  // ==========================================================
  // id field layout and encodings
  localparam logic [3:0] MSD_FSIZE_8M = 4'h6;
  localparam logic [3:0] MSD_SSIZE_64K = 4'h3;
  localparam logic [3:0] MSD_BSIZE_512K = 4'h3;
  localparam logic [1:0] MSD_BTYPE_FLASH = 2'h0;
  localparam logic [1:0] MSD_BTYPE_EEPROM = 2'h1;

  // ==========================================================
  // sizes
  localparam int MSD_N_MAIN = 8;
  localparam int MSD_N_BOOT = 4;
  localparam int MSD_N_PT = 3;

  // winning memory class after priority
  typedef enum logic [1:0]
  {
    MSD_WIN_NONE = 2'b00,
    MSD_WIN_SRAM = 2'b01,
    MSD_WIN_BOOT = 2'b10,
    MSD_WIN_MAIN = 2'b11
  } msd_win_type;

endpackage

/* logic/msd_region_match.sv */
/*
  one select region: an or of product terms, each an address and page
  window given as match value and care mask.
  assumes term configuration is static or changes between accesses.
*/
module msd_region_match
(
  input wire logic [15:0] addr_i,
  input wire logic [7:0] page_i,
  input wire logic [2:0][23:0] match_i,
  input wire logic [2:0][23:0] care_i,
  input wire logic [2:0] term_en_i,
  output logic hit_o
);

  logic [2:0] term_hit;

  // ==========================================================
  // product terms, up to three per select
  genvar g;
  generate
    for (g = 0; g < msd_pkg::MSD_N_PT; g++)
    begin : g_term
      assign term_hit[g] = term_en_i[g] &
        ((({page_i, addr_i} ^ match_i[g]) & care_i[g]) == 24'h000000);
    end
  endgenerate

  assign hit_o = |term_hit;

endmodule

/* logic/msd_decode.sv */
/*
  memory select and page decode: priority resolution of sram, boot and
  main flash selects, space-map strobe qualification, page register and
  read-only memory id registers in the config register space.
  assumes synchronous strobes from the mcu bus logic, one clock domain,
  and a select-equation configuration loaded from configuration ports.
*/
// Behaviour
// RL1 - three priority levels; higher level overrides lower at same address
// RL2 - configuration must not overlap two selects of one level
// RL3 - sram select region always wins the access
// RL4 - boot flash beats main flash when sram not selected
// RL5 - space-map loads configured value, mcu may rewrite any time
// RL6 - space-map bits gate code and data strobes per memory
// RL7 - separate spaces uses space-map value 0ch, written by mcu
// RL8 - both main flash enable bits set gives combined space
// RL9 - eight-bit page register, written and read at space base plus e0h
// RL10 - page bits feed select equations as extra address terms
// RL11 - page bits also exported for general logic equations
// RL12 - two eight-bit read-only id registers; writes ignored
// RL13 - id0: main flash size low nibble, sram size high nibble
// RL14 - id1: boot size bits 3:0, type bits 5:4, 7:6 zero
// RL15 - general logic input bus: address, strobes, reset, page, more
// RL16 - extended mcu mode feeds upper address bits to decoder
// RL17 - sram enabled only while its select is high, three terms
// RL18 - all memory selects are outputs of configured decode logic
// RL19 - register writes affect the first access after the write
// RL20 - at most one memory select asserted per access
module msd_decode
#(
  parameter logic [7:0] SPACE_MAP_INIT = 8'h0c,
  parameter logic [3:0] MAIN_SIZE_CODE = msd_pkg::MSD_FSIZE_8M,
  parameter logic [3:0] SRAM_SIZE_CODE = msd_pkg::MSD_SSIZE_64K,
  parameter logic [3:0] BOOT_SIZE_CODE = msd_pkg::MSD_BSIZE_512K,
  parameter logic [1:0] BOOT_TYPE_CODE = msd_pkg::MSD_BTYPE_FLASH
)
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [19:0] addr_i,
  input wire logic ext_addr_mode_i,
  input wire logic program_fetch_strobe_i,
  input wire logic data_read_strobe_i,
  input wire logic write_strobe_i,
  input wire logic [7:0] wdata_i,
  input wire logic config_reg_space_i,
  input wire logic power_down_in_i,
  input wire logic flash_ready_i,
  input wire logic [2:0][23:0] sram_match_i,
  input wire logic [2:0][23:0] sram_care_i,
  input wire logic [2:0] sram_term_en_i,
  input wire logic [3:0][2:0][23:0] boot_match_i,
  input wire logic [3:0][2:0][23:0] boot_care_i,
  input wire logic [3:0][2:0] boot_term_en_i,
  input wire logic [7:0][2:0][23:0] main_match_i,
  input wire logic [7:0][2:0][23:0] main_care_i,
  input wire logic [7:0][2:0] main_term_en_i,
  output logic [7:0] rdata_o,
  output logic sram_sel_o,
  output logic [3:0] boot_flash_sector_sel_o,
  output logic [7:0] main_flash_sector_sel_o,
  output logic periph_io_enable_o,
  output logic [7:0] page_bits_o,
  output logic [15:0] logic_addr_o,
  output logic [2:0] mcu_strobes_o,
  output logic logic_reset_o,
  output logic logic_power_down_o,
  output logic logic_flash_ready_o
);

  logic [7:0] page_extension_r;
  logic [7:0] space_map_r;
  logic [7:0] memory_size_info0;
  logic [7:0] memory_size_info1;
  logic [7:0] rdata_nxt;
  logic [15:0] dec_addr;
  logic sram_hit;
  logic [3:0] boot_hit;
  logic [7:0] main_hit;
  logic boot_any;
  logic main_any;
  logic strobe_ok_sram;
  logic strobe_ok_boot;
  logic strobe_ok_main;
  logic wr_page;
  logic wr_map;
  msd_pkg::msd_win_type win;

  // ==========================================================
  // decoder address selection
  assign dec_addr = ext_addr_mode_i ? addr_i[19:4] : addr_i[15:0]; // RL16

  // ==========================================================
  // select regions, page bits as extra address terms
  msd_region_match u_sram
  (
    .addr_i(dec_addr),
    .page_i(page_extension_r), // RL10
    .match_i(sram_match_i),
    .care_i(sram_care_i),
    .term_en_i(sram_term_en_i),
    .hit_o(sram_hit)
  );

  genvar gb;
  generate
    for (gb = 0; gb < msd_pkg::MSD_N_BOOT; gb++)
    begin : g_boot
      msd_region_match u_boot
      (
        .addr_i(dec_addr),
        .page_i(page_extension_r),
        .match_i(boot_match_i[gb]),
        .care_i(boot_care_i[gb]),
        .term_en_i(boot_term_en_i[gb]),
        .hit_o(boot_hit[gb])
      );
    end
    for (gb = 0; gb < msd_pkg::MSD_N_MAIN; gb++)
    begin : g_main
      msd_region_match u_main
      (
        .addr_i(dec_addr),
        .page_i(page_extension_r),
        .match_i(main_match_i[gb]),
        .care_i(main_care_i[gb]),
        .term_en_i(main_term_en_i[gb]),
        .hit_o(main_hit[gb])
      );
    end
  endgenerate

  assign boot_any = |boot_hit;
  assign main_any = |main_hit;

  // ==========================================================
  // strobe qualification by space-map
  assign strobe_ok_sram = data_read_strobe_i | write_strobe_i |
    (program_fetch_strobe_i & space_map_r[msd_pkg::MSD_SM_SRAM_CODE]); // RL6
  assign strobe_ok_boot = write_strobe_i |
    (data_read_strobe_i & space_map_r[msd_pkg::MSD_SM_BOOT_DATA]) |
    (program_fetch_strobe_i & space_map_r[msd_pkg::MSD_SM_BOOT_CODE]);
  // both main bits set lets either strobe through
  assign strobe_ok_main = write_strobe_i |
    (data_read_strobe_i & space_map_r[msd_pkg::MSD_SM_MAIN_FLASH_DATA_EN]) |
    (program_fetch_strobe_i & space_map_r[msd_pkg::MSD_SM_MAIN_FLASH_CODE_EN]); // RL8

  // ==========================================================
  // priority: sram, then boot, then main
  always_comb
  begin
    if (sram_hit) // RL1 RL3
      win = msd_pkg::MSD_WIN_SRAM;
    else if (boot_any) // RL4
      win = msd_pkg::MSD_WIN_BOOT;
    else if (main_any)
      win = msd_pkg::MSD_WIN_MAIN;
    else
      win = msd_pkg::MSD_WIN_NONE;
  end

  // ==========================================================
  // memory selects, one class at most
  always_comb
  begin
    sram_sel_o = 1'b0;
    boot_flash_sector_sel_o = 4'h0;
    main_flash_sector_sel_o = 8'h00;
    case (win) // RL18 RL20
      msd_pkg::MSD_WIN_SRAM:
        sram_sel_o = strobe_ok_sram; // RL17
      msd_pkg::MSD_WIN_BOOT:
        boot_flash_sector_sel_o = strobe_ok_boot ? boot_hit : 4'h0;
      msd_pkg::MSD_WIN_MAIN:
        main_flash_sector_sel_o = strobe_ok_main ? main_hit : 8'h00;
      default:
        sram_sel_o = 1'b0;
    endcase
  end

  // ==========================================================
  // register write decode
  assign wr_page = write_strobe_i & config_reg_space_i &
    (addr_i[7:0] == msd_pkg::MSD_OFS_PAGE);
  assign wr_map = write_strobe_i & config_reg_space_i &
    (addr_i[7:0] == msd_pkg::MSD_OFS_SPACE_MAP);

  // page register, effective from the next access
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      page_extension_r <= 8'h00;
    else if (wr_page)
      page_extension_r <= wdata_i; // RL9 RL19
  end

  // space-map, initial value then mcu rewrites
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      space_map_r <= SPACE_MAP_INIT; // RL5
    else if (wr_map)
      space_map_r <= wdata_i & msd_pkg::MSD_SM_USED_MASK; // RL5 RL7
  end

  // ==========================================================
  // id registers, constants only
  assign memory_size_info0 = {SRAM_SIZE_CODE, MAIN_SIZE_CODE}; // RL13
  assign memory_size_info1 = {2'b00, BOOT_TYPE_CODE, BOOT_SIZE_CODE}; // RL14

  // read mux
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (config_reg_space_i & data_read_strobe_i)
    begin
      case (addr_i[7:0])
        msd_pkg::MSD_OFS_PAGE: rdata_nxt = page_extension_r; // RL9
        msd_pkg::MSD_OFS_SPACE_MAP: rdata_nxt = space_map_r;
        msd_pkg::MSD_OFS_INFO0: rdata_nxt = memory_size_info0; // RL12
        msd_pkg::MSD_OFS_INFO1: rdata_nxt = memory_size_info1; // RL12
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // registered read data
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= rdata_nxt;
  end

  // ==========================================================
  // shared input bus toward general logic array
  assign page_bits_o = page_extension_r; // RL11
  assign logic_addr_o = dec_addr; // RL15
  assign mcu_strobes_o = {program_fetch_strobe_i, data_read_strobe_i,
    write_strobe_i};
  assign logic_reset_o = ~rst_n_i;
  assign logic_power_down_o = power_down_in_i;
  assign logic_flash_ready_o = flash_ready_i;
  assign periph_io_enable_o = space_map_r[msd_pkg::MSD_SM_PIO]; // RL6

  // ==========================================================
  // checks
  property p_one_class;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    !(sram_sel_o && ((|boot_flash_sector_sel_o) ||
      (|main_flash_sector_sel_o)));
  endproperty
  a_one_class: assert property (p_one_class) // RL20
    else $error("sram and flash selected together");

  property p_sram_wins;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (sram_hit && data_read_strobe_i) |-> (sram_sel_o &&
      boot_flash_sector_sel_o == 4'h0 && main_flash_sector_sel_o == 8'h00);
  endproperty
  a_sram_wins: assert property (p_sram_wins) // RL3
    else $error("sram region did not win");

  property p_boot_over_main;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (!sram_hit && boot_any && main_any) |->
      main_flash_sector_sel_o == 8'h00;
  endproperty
  a_boot_over_main: assert property (p_boot_over_main) // RL4
    else $error("main flash selected under boot region");

  property p_priority;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (|main_flash_sector_sel_o) |-> (!sram_hit && !boot_any);
  endproperty
  a_priority: assert property (p_priority) // RL1
    else $error("lower level selected over higher");

  property p_page_write;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    wr_page |=> page_bits_o == $past(wdata_i);
  endproperty
  a_page_write: assert property (p_page_write) // RL9
    else $error("page register not loaded");

  property p_page_readback;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (config_reg_space_i && data_read_strobe_i &&
      addr_i[7:0] == msd_pkg::MSD_OFS_PAGE) |=>
      rdata_o == $past(page_extension_r);
  endproperty
  a_page_readback: assert property (p_page_readback) // RL9
    else $error("page register readback wrong");

  property p_fetch_gate;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (program_fetch_strobe_i && !data_read_strobe_i && !write_strobe_i &&
      !space_map_r[msd_pkg::MSD_SM_MAIN_FLASH_CODE_EN]) |->
      main_flash_sector_sel_o == 8'h00;
  endproperty
  a_fetch_gate: assert property (p_fetch_gate) // RL6
    else $error("fetch reached main flash while disabled");

  property p_combined;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (space_map_r[msd_pkg::MSD_SM_MAIN_FLASH_CODE_EN] &&
      space_map_r[msd_pkg::MSD_SM_MAIN_FLASH_DATA_EN] && win == msd_pkg::MSD_WIN_MAIN &&
      (program_fetch_strobe_i || data_read_strobe_i)) |->
      main_flash_sector_sel_o == main_hit;
  endproperty
  a_combined: assert property (p_combined) // RL8
    else $error("combined space did not reach main flash");

  property p_id_fixed;
    @(posedge core_clk_i) disable iff (!rst_n_i)
    (config_reg_space_i && data_read_strobe_i &&
      addr_i[7:0] == msd_pkg::MSD_OFS_INFO1) |=>
      rdata_o[7:6] == 2'b00 && rdata_o[3:0] == BOOT_SIZE_CODE;
  endproperty
  a_id_fixed: assert property (p_id_fixed) // RL14
    else $error("id1 read wrong");

  c_sram: cover property (@(posedge core_clk_i) sram_sel_o);
  c_boot: cover property (@(posedge core_clk_i) |boot_flash_sector_sel_o);
  c_main: cover property (@(posedge core_clk_i) |main_flash_sector_sel_o);
  c_map_wr: cover property (@(posedge core_clk_i) wr_map);

endmodule

/* testbench/msd_mcu_model.sv */
/*
  mcu bus model for the memory select block: strobes, address, data.
  assumes the testbench calls its tasks and samples selects itself.
*/
module msd_mcu_model
(
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic [19:0] addr_o,
  output logic ext_o,
  output logic [2:0] strb_o,
  output logic [7:0] wdata_o,
  output logic cfg_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // idle bus at time zero
  initial
  begin
    addr_o = 20'h00000;
    ext_o = 1'b0;
    strb_o = 3'h0;
    wdata_o = 8'h00;
    cfg_o = 1'b0;
  end

  // release: strobes, cfg and ext drop, address and write data show the inverse
  task automatic idle();
    @(posedge clk_i);
    strb_o <= 3'h0;
    cfg_o <= 1'b0;
    ext_o <= 1'b0;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask

  // memory access, held until idle is called
  task automatic drive(input logic [2:0] k, input logic [19:0] a,
                       input logic e);
    @(posedge clk_i);
    strb_o <= k;
    addr_o <= a;
    ext_o <= e;
  endtask

  // config space write, one cycle of strobe
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    @(posedge clk_i);
    strb_o <= 3'h1;
    cfg_o <= 1'b1;
    addr_o <= {12'h000, ofs};
    wdata_o <= d;
    idle();
  endtask

  // config space read, data taken the cycle after the strobe
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    @(posedge clk_i);
    strb_o <= 3'h2;
    cfg_o <= 1'b1;
    addr_o <= {12'h000, ofs};
    idle();
    #10;
    d = rdata_i;
  endtask
endmodule

/* testbench/testbench.sv */
/*
  testbench for the memory select block: register and select checks.
  assumes the mcu bus model and the design compiled before it.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk, rst_n, pd, fr;
  logic [19:0] addr;
  logic ext;
  logic [2:0] strb, strobes;
  logic [7:0] wdata, rdata, page, d;
  logic cfg, sram_sel, pio, lrst, lpd, lfr;
  logic [2:0][23:0] s_m, s_c;
  logic [2:0] s_e;
  logic [3:0][2:0][23:0] b_m, b_c;
  logic [3:0][2:0] b_e;
  logic [7:0][2:0][23:0] m_m, m_c;
  logic [7:0][2:0] m_e;
  logic [3:0] boot_sel;
  logic [7:0] main_sel;
  logic [15:0] laddr;
  int mismatches, n_checks;

  // ==========================================================
  // instances
  msd_mcu_model i_mcu (.clk_i(core_clk), .rdata_i(rdata), .addr_o(addr),
    .ext_o(ext), .strb_o(strb), .wdata_o(wdata), .cfg_o(cfg));

  msd_decode #(.BOOT_TYPE_CODE(msd_pkg::MSD_BTYPE_EEPROM)) i_dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .addr_i(addr),
    .ext_addr_mode_i(ext), .program_fetch_strobe_i(strb[2]),
    .data_read_strobe_i(strb[1]), .write_strobe_i(strb[0]),
    .wdata_i(wdata), .config_reg_space_i(cfg), .power_down_in_i(pd),
    .flash_ready_i(fr), .sram_match_i(s_m), .sram_care_i(s_c),
    .sram_term_en_i(s_e), .boot_match_i(b_m), .boot_care_i(b_c),
    .boot_term_en_i(b_e), .main_match_i(m_m), .main_care_i(m_c),
    .main_term_en_i(m_e), .rdata_o(rdata), .sram_sel_o(sram_sel),
    .boot_flash_sector_sel_o(boot_sel), .main_flash_sector_sel_o(main_sel),
    .periph_io_enable_o(pio), .page_bits_o(page), .logic_addr_o(laddr),
    .mcu_strobes_o(strobes), .logic_reset_o(lrst),
    .logic_power_down_o(lpd), .logic_flash_ready_o(lfr));

  // ==========================================================
  // clock and watchdog
  always #25 core_clk = ~core_clk;

  initial
  begin
    #1000000;
    mismatches++;
    end_sim();
  end

  // verdict and end of run
  task automatic end_sim();
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // compare and count
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask

  // config read with expected value
  task automatic rdchk(input logic [7:0] ofs, input logic [7:0] e);
    i_mcu.rd(ofs, d);
    chk("rdata", {8'h00, e}, {8'h00, d});
  endtask

  // memory access: selects {sram, boot, main} and logic bus
  task automatic acc(input logic [2:0] k, input logic [19:0] a,
                     input logic e, input logic [12:0] sel);
    i_mcu.drive(k, a, e);
    #10;
    chk("selects", {3'h0, sel}, {3'h0, sram_sel, boot_sel, main_sel});
    chk("strobes", {13'h0, k}, {13'h0, strobes});
    chk("laddr", e ? a[19:4] : a[15:0], laddr);
    i_mcu.idle();
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    pd = 1'b0;
    fr = 1'b1;
    {s_m, s_c, s_e, b_m, b_c, b_e} = '0;
    {m_m, m_c, m_e} = '0;
    // sram 8000-87ff, boot0 8000-9fff, main0 8000-bfff, main1 page 01
    s_m[0] = 24'h008000;
    s_c[0] = 24'h00f800;
    s_e = 3'h1;
    b_m[0][0] = 24'h008000;
    b_c[0][0] = 24'h00e000;
    b_e[0] = 3'h1;
    m_m[0][0] = 24'h008000;
    m_c[0][0] = 24'h00c000;
    m_m[1][0] = 24'h010000;
    m_c[1][0] = 24'hffc000;
    m_e[0] = 3'h1;
    m_e[1] = 3'h1;
    repeat (7) @(posedge core_clk);
    #10;
    chk("lrst", 16'h0001, {15'h0, lrst});
    @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    #10;
    chk("lrst", 16'h0000, {15'h0, lrst});
    rdchk(msd_pkg::MSD_OFS_PAGE, 8'h00);
    rdchk(msd_pkg::MSD_OFS_SPACE_MAP, 8'h0c);
    rdchk(msd_pkg::MSD_OFS_INFO0,
      {msd_pkg::MSD_SSIZE_64K, msd_pkg::MSD_FSIZE_8M});
    rdchk(msd_pkg::MSD_OFS_INFO1, {2'h0, msd_pkg::MSD_BTYPE_EEPROM,
      msd_pkg::MSD_BSIZE_512K});
    i_mcu.wr(msd_pkg::MSD_OFS_INFO0, 8'hff);
    rdchk(msd_pkg::MSD_OFS_INFO0,
      {msd_pkg::MSD_SSIZE_64K, msd_pkg::MSD_FSIZE_8M});
    rdchk(8'h55, 8'h00);
    acc(3'h2, 20'h08000, 1'b0, 13'h1000);
    acc(3'h4, 20'h08000, 1'b0, 13'h0000);
    acc(3'h2, 20'h08800, 1'b0, 13'h0100);
    acc(3'h4, 20'h0a000, 1'b0, 13'h0001);
    acc(3'h2, 20'h0a000, 1'b0, 13'h0000);
    acc(3'h1, 20'h08000, 1'b0, 13'h1000);
    acc(3'h2, 20'h04000, 1'b0, 13'h0000);
    acc(3'h2, 20'h8a000, 1'b1, 13'h0100);
    i_mcu.wr(msd_pkg::MSD_OFS_SPACE_MAP, 8'h14);
    acc(3'h2, 20'h0a000, 1'b0, 13'h0001);
    acc(3'h4, 20'h0a000, 1'b0, 13'h0001);
    acc(3'h2, 20'h01000, 1'b0, 13'h0000);
    i_mcu.wr(msd_pkg::MSD_OFS_PAGE, 8'h01);
    acc(3'h2, 20'h01000, 1'b0, 13'h0002);
    i_mcu.wr(msd_pkg::MSD_OFS_PAGE, 8'h5a);
    rdchk(msd_pkg::MSD_OFS_PAGE, 8'h5a);
    chk("page_bits", 16'h005a, {8'h00, page});
    // data reads only reach main flash, fetches blocked
    i_mcu.wr(msd_pkg::MSD_OFS_SPACE_MAP, 8'h10);
    acc(3'h4, 20'h0a000, 1'b0, 13'h0000);
    acc(3'h2, 20'h0a000, 1'b0, 13'h0001);
    i_mcu.wr(msd_pkg::MSD_OFS_SPACE_MAP, 8'hff);
    rdchk(msd_pkg::MSD_OFS_SPACE_MAP, 8'h9f);
    chk("pio", 16'h0001, {15'h0, pio});
    // fetches into sram and boot flash now allowed
    acc(3'h4, 20'h08000, 1'b0, 13'h1000);
    acc(3'h4, 20'h08800, 1'b0, 13'h0100);
    i_mcu.wr(msd_pkg::MSD_OFS_SPACE_MAP, 8'h0c);
    #10;
    chk("pio", 16'h0000, {15'h0, pio});
    @(posedge core_clk);
    pd <= 1'b1;
    fr <= 1'b0;
    #10;
    chk("pd_fr", 16'h0002, {14'h0, lpd, lfr});
    end_sim();
  end
endmodule
